// File: logic/line_config_status_regs.v
// AXI4-Lite bank: per-channel pulse config, driver high-Z, Alarm_signal_status, irq
//
// The AXI4-Lite register port was chosen for this implementation.
`default_nettype none
`include "line_cfg_regs.vh"
module line_config_status_regs (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [`ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [`ADDR_WIDTH-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Line side: receiver AIS detectors
  input wire [7:0] ais_detect,
  // Line side: per-channel settings
  output reg [7:0] tx_driver_hiz,
  output reg [31:0] pulse_shape_select,
  output reg [7:0] impedance_internal_select,
  output reg [7:0] mode_e1,
  output reg [39:0] samples_per_ui,
  // Interrupt
  output reg irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  reg [4:0] cfg_q [0:7];
  reg [2:0] channel_pointer_q;
  reg [7:0] hiz_q;
  reg [7:0] ais_q;
  reg [7:0] ais_prev_q;
  reg [7:0] irq_status_q;
  reg [7:0] irq_mask_q;

  // Write channel holding
  reg aw_held_q;
  reg w_held_q;
  reg [`ADDR_WIDTH-1:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  function [7:0] reg_index;
    input [`ADDR_WIDTH-1:0] addr;
    begin
      reg_index = addr[9:2];
    end
  endfunction

  function known_index;
    input [7:0] idx;
    begin
      known_index = (idx >= `IDX_CHANNEL_POINTER) &&
                    (idx <= `IDX_IRQ_MASK);
    end
  endfunction

  // Unmapped words answer with an error; the access itself is dropped
  function [1:0] access_resp;
    input [7:0] idx;
    begin
      access_resp = known_index(idx) ? `RESP_OKAY : `RESP_SLVERR;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write path: address and data taken in either order

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= {`ADDR_WIDTH{1'b0}};
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      // Each ready only while its own beat is not held and no response is pending, so a beat is never overwritten
      s_axi_awready <= ~aw_held_q & ~(s_axi_awvalid & s_axi_awready) &
                       ~s_axi_bvalid;
      s_axi_wready <= ~w_held_q & ~(s_axi_wvalid & s_axi_wready) &
                      ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (aw_held_q & w_held_q & ~s_axi_bvalid) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= access_resp(reg_index(aw_addr_q));
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Commit only from held beats so the response is one cycle later
  wire commit = aw_held_q & w_held_q & ~s_axi_bvalid & w_strb_q[0];
  wire [7:0] cm_idx = reg_index(aw_addr_q);
  wire [7:0] cm_byte = w_data_q[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Register updates

  integer i;
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < `NUM_CHANNELS; i = i + 1) begin
        cfg_q[i] <= 5'h00;
      end
      channel_pointer_q <= 3'h0;
      hiz_q <= `RESET_BYTE;
      irq_mask_q <= `RESET_BYTE;
    end else if (commit) begin
      case (cm_idx)
        `IDX_CHANNEL_POINTER: begin
          channel_pointer_q <= cm_byte[2:0];
        end
        `IDX_LINE_PULSE_CONFIG: begin
          // Reserved bits dropped; software keeps them zero
          cfg_q[channel_pointer_q] <= cm_byte[4:0];
        end
        `IDX_TX_HIGH_Z_CONTROL: begin
          hiz_q <= cm_byte;
        end
        `IDX_IRQ_MASK: begin
          irq_mask_q <= cm_byte;
        end
        `IDX_ALARM_SIGNAL_STATUS: begin
          // Read-only: the detectors own these bits
        end
        `IDX_IRQ_STATUS: begin
          // Write-one-to-clear is applied next to the event logic
        end
        default: begin
          // Unmapped words are answered with an error and dropped
        end
      endcase
    end
  end

  // AIS level and change-of-state status; set wins over write-one-clear
  wire [7:0] ais_change = ais_q ^ ais_prev_q;
  wire [7:0] irq_clear = (commit && cm_idx == `IDX_IRQ_STATUS) ?
                         cm_byte : 8'h00;
  always @(posedge aclk) begin
    if (!aresetn) begin
      ais_q <= `RESET_BYTE;
      ais_prev_q <= `RESET_BYTE;
      irq_status_q <= `RESET_BYTE;
    end else begin
      ais_q <= ais_detect;
      ais_prev_q <= ais_q;
      irq_status_q <= (irq_status_q & ~irq_clear) | ais_change;
    end
  end

  // Registered pin, so it lags the status bits by one cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_q & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  reg [7:0] rd_byte;
  wire [7:0] rd_idx = reg_index(s_axi_araddr);
  always @* begin
    case (rd_idx)
      `IDX_CHANNEL_POINTER: begin
        rd_byte = {5'h00, channel_pointer_q};
      end
      `IDX_LINE_PULSE_CONFIG: begin
        // Reserved bits are not stored and read back as zero
        rd_byte = {3'h0, cfg_q[channel_pointer_q]};
      end
      `IDX_TX_HIGH_Z_CONTROL: begin
        rd_byte = hiz_q;
      end
      `IDX_ALARM_SIGNAL_STATUS: begin
        rd_byte = ais_q;
      end
      `IDX_IRQ_STATUS: begin
        rd_byte = irq_status_q;
      end
      `IDX_IRQ_MASK: begin
        rd_byte = irq_mask_q;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= known_index(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel decode and line-side outputs

  wire [7:0] dec_e1;
  wire [39:0] dec_samples;
  genvar g;
  generate
    for (g = 0; g < `NUM_CHANNELS; g = g + 1) begin : ch
      shape_decode u_dec (
        .shape_code(cfg_q[g][`CFG_SHAPE_MSB:`CFG_SHAPE_LSB]),
        .mode_e1(dec_e1[g]),
        .samples_per_ui(dec_samples[5*g+4:5*g]),
        // Unlisted codes already fall back to E1, so the flag is unused
        .code_valid()
      );
    end
  endgenerate

  // One process drives each vector; code zero is E1 at 12 samples
  integer j;
  always @(posedge aclk) begin
    if (!aresetn) begin
      pulse_shape_select <= 32'h00000000;
      impedance_internal_select <= `RESET_BYTE;
      mode_e1 <= 8'hFF;
      samples_per_ui <= {`NUM_CHANNELS{`SAMPLES_E1}};
    end else begin
      for (j = 0; j < `NUM_CHANNELS; j = j + 1) begin
        pulse_shape_select[4*j +: 4] <= cfg_q[j][3:0];
        impedance_internal_select[j] <= cfg_q[j][`CFG_IMPED_BIT];
        mode_e1[j] <= dec_e1[j];
      end
      samples_per_ui <= dec_samples;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_driver_hiz <= `RESET_BYTE;
    end else begin
      tx_driver_hiz <= hiz_q;
    end
  end

endmodule // line_config_status_regs
`default_nettype wire

// File: shared/line_cfg_regs.vh
// Register map, field positions, reset values and codes of the config bank
`ifndef LINE_CFG_REGS_VH
`define LINE_CFG_REGS_VH
// Register indices; the byte address is four times the index
`define IDX_CHANNEL_POINTER 8'h10
`define IDX_LINE_PULSE_CONFIG 8'h11
`define IDX_TX_HIGH_Z_CONTROL 8'h12
`define IDX_ALARM_SIGNAL_STATUS 8'h13
`define IDX_IRQ_STATUS 8'h14
`define IDX_IRQ_MASK 8'h15
`define ADDR_WIDTH 10
`define NUM_CHANNELS 8
`define CFG_SHAPE_LSB 0
`define CFG_SHAPE_MSB 3
`define CFG_IMPED_BIT 4
`define CFG_WRITE_MASK 8'h1F
`define PTR_MASK 8'h07
`define RESET_BYTE 8'h00
`define SHAPE_E1_120 4'h0
`define SHAPE_DS1_UNDER 4'h1
`define SHAPE_DS1_0DB 4'h2
`define SHAPE_CAB_FIRST 4'h3
`define SHAPE_CAB_LAST 4'h7
`define SHAPE_E1_75 4'h8
`define SAMPLES_E1 5'h0C
`define SAMPLES_DS1 5'h0E
`define SAMPLES_CABLE 5'h0D
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: logic/shape_decode.v
// Per-channel decode of a pulse shape code into standard and sample count
`default_nettype none
`include "line_cfg_regs.vh"
module shape_decode (
  // Shape code of one channel
  input wire [3:0] shape_code,
  // Decoded settings
  output reg mode_e1,
  output reg [4:0] samples_per_ui,
  output reg code_valid
);
  always @* begin
    mode_e1 = 1'b0;
    samples_per_ui = `SAMPLES_E1;
    code_valid = 1'b1;
    if (shape_code == `SHAPE_E1_120 || shape_code == `SHAPE_E1_75) begin
      mode_e1 = 1'b1;
      samples_per_ui = `SAMPLES_E1;
    end else if (shape_code == `SHAPE_DS1_UNDER ||
                 shape_code == `SHAPE_DS1_0DB) begin
      samples_per_ui = `SAMPLES_DS1;
    end else if (shape_code >= `SHAPE_CAB_FIRST &&
                 shape_code <= `SHAPE_CAB_LAST) begin
      samples_per_ui = `SAMPLES_CABLE;
    end else begin
      // Unlisted codes fall back to E1 120 ohm behaviour
      mode_e1 = 1'b1;
      code_valid = 1'b0;
    end
  end
endmodule // shape_decode
`default_nettype wire

// File: test/line_cfg_asserts.sv
// Port-level checks of the line config bank
`default_nettype none
module line_cfg_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Line side
  input wire logic [7:0] tx_driver_hiz,
  input wire logic [31:0] pulse_shape_select,
  input wire logic [7:0] mode_e1,
  input wire logic [39:0] samples_per_ui
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wd_q;
  logic wr_go;
  logic [3:0] sh;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready;
  assign sh = pulse_shape_select[3:0];
  always @(posedge aclk) begin
    if (s_axi_wvalid && s_axi_wready) begin
      wd_q <= s_axi_wdata[7:0];
    end
  end
  //////////////////////////////////////////////////////////////
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |-> ##[1:2] s_axi_rvalid) else $error("read answer late");
  a_write_answer: assert property (wr_go |-> ##[2:3] s_axi_bvalid)
    else $error("write answer late");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_unmapped_err: assert property (wr_go && s_axi_awaddr > 10'h057
    |-> ##[2:3] s_axi_bvalid && s_axi_bresp == 2'h2) else $error("no error");
  a_hiz_follows: assert property (
    wr_go && s_axi_wstrb[0] && s_axi_awaddr == 10'h048 |-> ##4
    tx_driver_hiz == wd_q)
    else $error("driver high-Z not updated");
  a_shape_samples: assert property (
    $stable(sh) ##1 $stable(sh) |-> samples_per_ui[4:0] ==
    ((sh == 4'h0 || sh > 4'h7) ? 5'h0C : (sh < 4'h3) ? 5'h0E : 5'h0D))
    else $error("sample count decode wrong");
  a_shape_mode: assert property (
    $stable(sh) ##1 $stable(sh) |-> mode_e1[0] == (sh == 4'h0 || sh > 4'h7))
    else $error("operating standard decode wrong");
endmodule // line_cfg_asserts
bind line_config_status_regs line_cfg_asserts u_chk (.*);
`default_nettype wire

// File: test/line_side_model.sv
// Line side stand-in: receivers reporting AIS per channel
`default_nettype none
module line_side_model (
  // Clock
  input wire logic aclk,
  // Alarm pattern commanded by the bench
  input wire logic [7:0] ais_set,
  // Receiver detect levels
  output logic [7:0] ais_detect
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ais_detect = 8'h00;
  // Registered, so the level never moves mid-cycle
  always @(posedge aclk) ais_detect <= ais_set;
endmodule // line_side_model
`default_nettype wire

// File: test/tb.sv
// Directed register-bus test of the line config bank
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, pulse_shape_select;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] ais_set = 8'h00, ais_detect, tx_driver_hiz;
  logic [7:0] impedance_internal_select, mode_e1;
  logic [39:0] samples_per_ui;
  int error_cnt = 0, n_tests = 0;
  logic [31:0] exp_spu;
  always #2 aclk = ~aclk;
  line_config_status_regs u_dut (.*);
  line_side_model u_line (.*);
  //////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] ex, got);
    n_tests++;
    if (got !== ex) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] ex,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", ex, s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(10'h044, 32'h0, 2'h0);
    rd(10'h048, 32'h0, 2'h0);
    rd(10'h04C, 32'h0, 2'h0);
    // Code i on channel i, internal matching on odd channels
    for (int i = 0; i < 8; i++) begin
      wr(10'h040, i, 2'h0);
      wr(10'h044, {27'h0, i[0], i[3:0]}, 2'h0);
    end
    for (int i = 0; i < 8; i++) begin
      wr(10'h040, i, 2'h0);
      rd(10'h040, i, 2'h0);
      rd(10'h044, {27'h0, i[0], i[3:0]}, 2'h0);
      chk("shape", i, 32'(pulse_shape_select[4*i +: 4]));
      chk("imped", 32'(i[0]), 32'(impedance_internal_select[i]));
      chk("e1", 32'(i == 0), 32'(mode_e1[i]));
      exp_spu = (i == 0) ? 32'hC : (i < 3) ? 32'hE : 32'hD;
      chk("spu", exp_spu, 32'(samples_per_ui[5*i +: 5]));
    end
    wr(10'h040, 32'h0, 2'h0);
    wr(10'h044, 32'h18, 2'h0);
    repeat (2) @(posedge aclk);
    chk("e1", 32'h1, 32'(mode_e1[0]));
    chk("spu", 32'hC, 32'(samples_per_ui[4:0]));
    chk("shape", 32'h1, 32'(pulse_shape_select[7:4]));
    chk("shape", 32'h8, 32'(pulse_shape_select[3:0]));
    chk("imped", 32'h1, 32'(impedance_internal_select[0]));
    wr(10'h048, 32'hA5, 2'h0);
    repeat (2) @(posedge aclk);
    chk("hiz", 32'hA5, 32'(tx_driver_hiz));
    // Lane 0 strobe low: the write must leave the register alone
    s_axi_wstrb <= 4'hE;
    wr(10'h048, 32'h0, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(10'h048, 32'hA5, 2'h0);
    ais_set <= 8'h5A;
    repeat (3) @(posedge aclk);
    rd(10'h04C, 32'h5A, 2'h0);
    wr(10'h04C, 32'hFF, 2'h0);
    rd(10'h04C, 32'h5A, 2'h0);
    wr(10'h054, 32'h0, 2'h0);
    rd(10'h050, 32'h5A, 2'h0);
    chk("irq", 32'h0, 32'(irq));
    wr(10'h054, 32'hFF, 2'h0);
    repeat (2) @(posedge aclk);
    chk("irq", 32'h1, 32'(irq));
    wr(10'h050, 32'hFF, 2'h0);
    repeat (2) @(posedge aclk);
    chk("irq", 32'h0, 32'(irq));
    wr(10'h3FC, 32'hFF, 2'h2);
    rd(10'h3FC, 32'h0, 2'h2);
    // Second reset with registers loaded
    aresetn <= 1'b0;
    ais_set <= 8'h00;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(10'h044, 32'h0, 2'h0);
    chk("hiz", 32'h0, 32'(tx_driver_hiz));
    rd(10'h04C, 32'h0, 2'h0);
    end_sim();
  end
  initial begin
    repeat (5000) @(posedge aclk);
    error_cnt++;
    end_sim();
  end
endmodule // tb
`default_nettype wire
